// >>> src/framer_pkg.sv
package framer_pkg;

  // clock and latency time base
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  localparam int unsigned LAT_FINE_MS = 10;
  localparam int unsigned LAT_COARSE_MS = 2560;
  localparam int unsigned FINE_TICK_CYCLES = CLK_FREQ_HZ / 1000 * LAT_FINE_MS;
  localparam int unsigned COARSE_TICK_CYCLES =
    CLK_FREQ_HZ / 1000 * LAT_COARSE_MS;

  // packet types and message details
  localparam logic [7:0] PTYPE_EVENT = 8'h02;
  localparam logic [7:0] PTYPE_SERIAL = 8'h10;
  localparam logic [7:0] DETAIL_PATH = 8'h20;
  localparam logic [7:0] DETAIL_CFG = 8'h21;
  localparam logic [7:0] DETAIL_CAL = 8'h22;
  localparam logic [7:0] DETAIL_RESET = 8'h30;

  // byte positions inside a packet
  localparam logic [7:0] POS_SYSID = 8'h00;
  localparam logic [7:0] POS_NODE = 8'h04;
  localparam logic [7:0] POS_STRENGTH = 8'h08;
  localparam logic [7:0] POS_DEPTH = 8'h09;
  localparam logic [7:0] POS_HOPS = 8'h0A;
  localparam logic [7:0] POS_MSG = 8'h0B;
  localparam logic [7:0] POS_LAT = 8'h0D;
  localparam logic [7:0] POS_PTYPE = 8'h0F;
  localparam logic [7:0] POS_DETAIL = 8'h12;
  localparam logic [7:0] POS_PAYLOAD = 8'h13;
  localparam logic [7:0] POS_LAST_MAX = 8'h8A;

  // serial block counter limits, weak link threshold
  localparam logic [7:0] BLOCK_FIRST = 8'h01;
  localparam logic [7:0] BLOCK_MAX = 8'hFF;
  localparam logic [7:0] WEAK_STRENGTH = 8'hBE;
  localparam logic [15:0] LATENCY_MAX = 16'hFFFF;

  // register word addresses
  localparam logic [3:0] ADDR_SYSID = 4'h0;
  localparam logic [3:0] ADDR_NODE = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_LINK = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_LATENCY = 4'h5;

  // reset values
  localparam logic [31:0] SYSID_RST = 32'h0000_0000;
  localparam logic [31:0] NODE_RST = 32'h0000_0000;
  localparam logic [7:0] LIMIT_RST = 8'hBE;
  localparam logic [7:0] STRENGTH_RST = 8'hFF;
  localparam logic [7:0] DEPTH_RST = 8'h00;

  typedef enum logic [2:0] {
    KIND_PATH = 3'h0,
    KIND_CFG = 3'h1,
    KIND_CAL = 3'h2,
    KIND_SERIAL = 3'h3,
    KIND_FWD = 3'h4,
    KIND_RESET = 3'h5
  } kind_type;

  typedef struct packed {
    logic [31:0] network_system_identifier;
    logic [31:0] originator_node_identifier;
    logic [7:0] first_link_signal_strength;
    logic [7:0] origin_hop_depth;
    logic [7:0] hop_count;
    logic [15:0] msg_count;
    logic [15:0] transit_latency_timer;
    logic [7:0] ptype;
    logic [7:0] detail;
  } header_type;

  typedef struct packed {
    kind_type kind;
    logic streamed;
    logic stream_end;
    header_type fwd;
  } req_type;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } beat_type;

endpackage

// >>> src/latency_timer.sv
`timescale 1ns/1ps
module latency_timer #(
  parameter int unsigned FINE_CYCLES = 1,
  parameter int unsigned COARSE_CYCLES = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [15:0] start_value,
  input wire logic tick_sel,
  output logic [15:0] value
);
  import framer_pkg::*;

  logic [31:0] pre_q;
  logic [31:0] pre_d;
  logic [15:0] val_q;
  logic [15:0] val_d;
  logic [31:0] period;

  always_comb begin
    period = tick_sel ? COARSE_CYCLES : FINE_CYCLES;
    pre_d = pre_q + 32'h0000_0001;
    val_d = val_q;
    if (start) begin
      pre_d = 32'h0000_0000;
      val_d = start_value;
    end else if (pre_q >= period - 32'h0000_0001) begin
      pre_d = 32'h0000_0000;
      if (val_q != LATENCY_MAX) begin
        val_d = val_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= 32'h0000_0000;
      val_q <= 16'h0000;
    end else begin
      pre_q <= pre_d;
      val_q <= val_d;
    end
  end

  assign value = val_q;

endmodule // latency_timer

// >>> src/event_packet_framer.sv
`timescale 1ns/1ps
module event_packet_framer
  import framer_pkg::*;
#(
  parameter int unsigned FINE_CYCLES = framer_pkg::FINE_TICK_CYCLES,
  parameter int unsigned COARSE_CYCLES = framer_pkg::COARSE_TICK_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic REQ_VALID,
  input wire framer_pkg::req_type REQ,
  output logic REQ_READY,
  input wire logic FORCE_RESET_CMD,
  input wire logic CONFIG_SET_DONE,
  input wire logic SRC_VALID,
  input wire logic [7:0] SRC_DATA,
  input wire logic SRC_LAST,
  output logic SRC_READY,
  output logic TX_VALID,
  output framer_pkg::beat_type TX_BEAT,
  input wire logic TX_READY,
  input wire logic CAND_VALID,
  input wire logic [7:0] CAND_STRENGTH,
  output logic LINK_ACCEPT_VALID,
  output logic LINK_ACCEPT,
  output logic WEAK_ORIGIN_LINK
);
  import framer_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HDR = 3'b010,
    ST_BODY = 3'b100
  } state_type;

  //////////////////////////////////////////////////////////////////////////
  // register file

  logic [31:0] sysid_q;
  logic [31:0] sysid_d;
  logic [31:0] node_q;
  logic [31:0] node_d;
  logic [7:0] limit_q;
  logic [7:0] limit_d;
  logic tick_sel_q;
  logic tick_sel_d;
  logic [7:0] strength_q;
  logic [7:0] strength_d;
  logic [7:0] depth_q;
  logic [7:0] depth_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic acc_valid_q;
  logic acc_valid_d;
  logic accept_q;
  logic accept_d;
  logic weak_q;
  logic weak_d;

  // framer state, declared here for status reads
  state_type state_q;
  state_type state_d;
  logic [15:0] msg_cnt_q;
  logic [15:0] msg_cnt_d;
  logic [7:0] blk_q;
  logic [7:0] blk_d;
  logic rst_pend_q;
  logic rst_pend_d;
  logic [15:0] lat_value;

  always_comb begin
    sysid_d = sysid_q;
    node_d = node_q;
    limit_d = limit_q;
    tick_sel_d = tick_sel_q;
    strength_d = strength_q;
    depth_d = depth_q;
    rdata_d = 32'h0000_0000;
    acc_valid_d = CAND_VALID;
    accept_d = accept_q;
    if (REG_WR) begin
      case (REG_ADDR)
        ADDR_SYSID: sysid_d = REG_WDATA;
        ADDR_NODE: node_d = REG_WDATA;
        ADDR_CTRL: begin
          limit_d = REG_WDATA[15:8];
          tick_sel_d = REG_WDATA[0];
        end
        ADDR_LINK: begin
          depth_d = REG_WDATA[15:8];
          strength_d = REG_WDATA[7:0];
        end
        default: ;
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_SYSID: rdata_d = sysid_q;
        ADDR_NODE: rdata_d = node_q;
        ADDR_CTRL: rdata_d = {16'h0000, limit_q, 7'h00, tick_sel_q};
        ADDR_LINK: rdata_d = {16'h0000, depth_q, strength_q};
        ADDR_STATUS: rdata_d = {msg_cnt_q, blk_q, 5'h00, rst_pend_q,
                                state_q != ST_IDLE, weak_q};
        ADDR_LATENCY: rdata_d = {16'h0000, lat_value};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (CAND_VALID) begin
      accept_d = CAND_STRENGTH <= limit_q;
    end
    weak_d = strength_q > WEAK_STRENGTH;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sysid_q <= SYSID_RST;
      node_q <= NODE_RST;
      limit_q <= LIMIT_RST;
      tick_sel_q <= 1'b0;
      strength_q <= STRENGTH_RST;
      depth_q <= DEPTH_RST;
      rdata_q <= 32'h0000_0000;
      acc_valid_q <= 1'b0;
      accept_q <= 1'b0;
      weak_q <= 1'b0;
    end else begin
      sysid_q <= sysid_d;
      node_q <= node_d;
      limit_q <= limit_d;
      tick_sel_q <= tick_sel_d;
      strength_q <= strength_d;
      depth_q <= depth_d;
      rdata_q <= rdata_d;
      acc_valid_q <= acc_valid_d;
      accept_q <= accept_d;
      weak_q <= weak_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // latency timer

  logic lat_start;
  logic [15:0] lat_init;

  latency_timer #(
    .FINE_CYCLES(FINE_CYCLES),
    .COARSE_CYCLES(COARSE_CYCLES)
  ) u_latency (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .start(lat_start),
    .start_value(lat_init),
    .tick_sel(tick_sel_q),
    .value(lat_value)
  );

  //////////////////////////////////////////////////////////////////////////
  // framer

  header_type hdr_q;
  header_type hdr_d;
  kind_type kind_q;
  kind_type kind_d;
  logic [7:0] pos_q;
  logic [7:0] pos_d;
  logic [15:0] lat_hold_q;
  logic [15:0] lat_hold_d;
  logic end_q;
  logic end_d;
  logic src_done_q;
  logic src_done_d;
  logic src_ready_q;
  logic src_ready_d;
  logic req_ready_q;
  logic req_ready_d;
  logic tx_valid_q;
  logic tx_valid_d;
  beat_type tx_q;
  beat_type tx_d;

  always_comb begin
    header_type own;
    logic tx_free;
    logic [7:0] hb;
    logic [7:0] blk_next;
    own = '0;
    tx_free = !tx_valid_q || TX_READY;
    hb = 8'h00;
    blk_next = (blk_q == BLOCK_MAX) ? BLOCK_FIRST : blk_q + 8'h01;
    state_d = state_q;
    hdr_d = hdr_q;
    kind_d = kind_q;
    pos_d = pos_q;
    lat_hold_d = lat_hold_q;
    end_d = end_q;
    src_done_d = src_done_q;
    msg_cnt_d = msg_cnt_q;
    blk_d = blk_q;
    rst_pend_d = rst_pend_q;
    tx_valid_d = tx_valid_q && !TX_READY;
    tx_d = tx_q;
    lat_start = 1'b0;
    lat_init = 16'h0000;
    // common header fields of a created packet
    own.network_system_identifier = sysid_q;
    own.originator_node_identifier = node_q;
    own.first_link_signal_strength = strength_q;
    own.origin_hop_depth = depth_q;
    own.msg_count = msg_cnt_q;
    own.ptype = PTYPE_EVENT;
    case (state_q)
      ST_IDLE: begin
        if (rst_pend_q) begin
          hdr_d = own;
          hdr_d.detail = DETAIL_RESET;
          kind_d = KIND_RESET;
          rst_pend_d = 1'b0;
          msg_cnt_d = msg_cnt_q + 16'h0001;
          lat_start = 1'b1;
          pos_d = POS_SYSID;
          state_d = ST_HDR;
        end else if (REQ_VALID && req_ready_q) begin
          hdr_d = own;
          kind_d = REQ.kind;
          end_d = REQ.stream_end;
          src_done_d = 1'b0;
          pos_d = POS_SYSID;
          state_d = ST_HDR;
          lat_start = 1'b1;
          msg_cnt_d = msg_cnt_q + 16'h0001;
          case (REQ.kind)
            KIND_PATH: hdr_d.detail = DETAIL_PATH;
            KIND_CFG: hdr_d.detail = DETAIL_CFG;
            KIND_CAL: hdr_d.detail = DETAIL_CAL;
            KIND_SERIAL: begin
              hdr_d.ptype = PTYPE_SERIAL;
              if (REQ.streamed) begin
                hdr_d.detail = blk_next;
                blk_d = blk_next;
              end else begin
                hdr_d.detail = 8'h00;
                blk_d = 8'h00;
              end
            end
            KIND_FWD: begin
              hdr_d = REQ.fwd;
              hdr_d.hop_count = REQ.fwd.hop_count + 8'h01;
              lat_init = REQ.fwd.transit_latency_timer;
              msg_cnt_d = msg_cnt_q;
            end
            default: begin
              kind_d = KIND_CFG;
              hdr_d.detail = DETAIL_CFG;
            end
          endcase
        end
      end
      ST_HDR: begin
        if (tx_free) begin
          case (pos_q)
            8'h00: hb = hdr_q.network_system_identifier[31:24];
            8'h01: hb = hdr_q.network_system_identifier[23:16];
            8'h02: hb = hdr_q.network_system_identifier[15:8];
            8'h03: hb = hdr_q.network_system_identifier[7:0];
            8'h04: hb = hdr_q.originator_node_identifier[31:24];
            8'h05: hb = hdr_q.originator_node_identifier[23:16];
            8'h06: hb = hdr_q.originator_node_identifier[15:8];
            8'h07: hb = hdr_q.originator_node_identifier[7:0];
            8'h08: hb = hdr_q.first_link_signal_strength;
            8'h09: hb = hdr_q.origin_hop_depth;
            8'h0A: hb = hdr_q.hop_count;
            8'h0B: hb = hdr_q.msg_count[15:8];
            8'h0C: hb = hdr_q.msg_count[7:0];
            8'h0D: hb = lat_value[15:8];
            8'h0E: hb = lat_hold_q[7:0];
            8'h0F: hb = hdr_q.ptype;
            8'h12: hb = hdr_q.detail;
            default: hb = 8'h00;
          endcase
          if (pos_q == POS_LAT) begin
            lat_hold_d = lat_value;
          end
          tx_valid_d = 1'b1;
          tx_d.data = hb;
          tx_d.last = (pos_q == POS_DETAIL) && (kind_q == KIND_RESET);
          pos_d = pos_q + 8'h01;
          if (pos_q == POS_DETAIL) begin
            state_d = (kind_q == KIND_RESET) ? ST_IDLE : ST_BODY;
          end
        end
      end
      ST_BODY: begin
        if (src_done_q) begin
          // pad calibration data to 120 bytes
          if (tx_free) begin
            tx_valid_d = 1'b1;
            tx_d.data = 8'h00;
            tx_d.last = pos_q == POS_LAST_MAX;
            pos_d = pos_q + 8'h01;
            if (pos_q == POS_LAST_MAX) begin
              state_d = ST_IDLE;
            end
          end
        end else if (SRC_VALID && src_ready_q) begin
          tx_valid_d = 1'b1;
          tx_d.data = SRC_DATA;
          pos_d = pos_q + 8'h01;
          // stop when full or at the last source byte, except for calibration
          tx_d.last = (pos_q == POS_LAST_MAX) ||
                      (SRC_LAST && kind_q != KIND_CAL);
          if (SRC_LAST) begin
            src_done_d = 1'b1;
          end
          if (tx_d.last) begin
            state_d = ST_IDLE;
            if (kind_q == KIND_SERIAL && end_q) begin
              blk_d = 8'h00;
            end
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // restart numbering with a reset notice
    if (FORCE_RESET_CMD || CONFIG_SET_DONE) begin
      rst_pend_d = 1'b1;
      msg_cnt_d = 16'h0000;
    end
    src_ready_d = (state_d == ST_BODY) && !src_done_d && !tx_valid_d;
    req_ready_d = (state_d == ST_IDLE) && !rst_pend_d;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= ST_IDLE;
      hdr_q <= '0;
      kind_q <= KIND_PATH;
      pos_q <= 8'h00;
      lat_hold_q <= 16'h0000;
      end_q <= 1'b0;
      src_done_q <= 1'b0;
      msg_cnt_q <= 16'h0000;
      blk_q <= 8'h00;
      rst_pend_q <= 1'b1;
      src_ready_q <= 1'b0;
      req_ready_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_q <= '0;
    end else begin
      state_q <= state_d;
      hdr_q <= hdr_d;
      kind_q <= kind_d;
      pos_q <= pos_d;
      lat_hold_q <= lat_hold_d;
      end_q <= end_d;
      src_done_q <= src_done_d;
      msg_cnt_q <= msg_cnt_d;
      blk_q <= blk_d;
      rst_pend_q <= rst_pend_d;
      src_ready_q <= src_ready_d;
      req_ready_q <= req_ready_d;
      tx_valid_q <= tx_valid_d;
      tx_q <= tx_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign REQ_READY = req_ready_q;
  assign SRC_READY = src_ready_q;
  assign TX_VALID = tx_valid_q;
  assign TX_BEAT = tx_q;
  assign LINK_ACCEPT_VALID = acc_valid_q;
  assign LINK_ACCEPT = accept_q;
  assign WEAK_ORIGIN_LINK = weak_q;

endmodule // event_packet_framer

// >>> bench/framer_assertions.sv
`timescale 1ns/1ps
module framer_checker (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic SRC_VALID,
  input wire logic [7:0] SRC_DATA,
  input wire logic SRC_READY,
  input wire logic TX_VALID,
  input wire framer_pkg::beat_type TX_BEAT,
  input wire logic TX_READY,
  input wire logic CAND_VALID,
  input wire logic LINK_ACCEPT_VALID,
  input wire logic LINK_ACCEPT,
  input wire logic WEAK_ORIGIN_LINK
);
  import framer_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data not zero outside read answer");
  tx_hold_a: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BEAT))
    else $error("output byte changed while stalled");
  first_byte_a: assert property (
    REQ_VALID && REQ_READY |=> ##1 TX_VALID)
    else $error("no header byte after request taken");
  ready_drop_a: assert property (REQ_VALID && REQ_READY |=> !REQ_READY)
    else $error("request ready stayed high while busy");
  payload_pass_a: assert property (
    SRC_VALID && SRC_READY |=> TX_VALID && TX_BEAT.data == $past(SRC_DATA))
    else $error("taken payload byte not presented next cycle");
  accept_pulse_a: assert property (CAND_VALID |=> LINK_ACCEPT_VALID)
    else $error("no link verdict after candidate");
  accept_only_a: assert property (
    LINK_ACCEPT_VALID |-> $past(CAND_VALID))
    else $error("link verdict without candidate");
  accept_hold_a: assert property (
    !$past(CAND_VALID) |-> $stable(LINK_ACCEPT))
    else $error("link verdict changed without candidate");
  weak_link_a: assert property (
    (REG_WR && REG_ADDR == ADDR_LINK) ##1 !(REG_WR && REG_ADDR == ADDR_LINK)
    |=> WEAK_ORIGIN_LINK == ($past(REG_WDATA[7:0], 2) > WEAK_STRENGTH))
    else $error("weak origin flag does not match strength");
  notice_start_a: assert property ($rose(RST_B) |-> ##[1:3] TX_VALID)
    else $error("no reset notice after reset release");
endmodule // framer_checker

// >>> bench/host_sink.sv
`timescale 1ns/1ps
module host_sink (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  output logic tx_ready
);
  logic [1:0] phase_q;
  // slow mode takes one byte in three cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
    end
  end
  assign tx_ready = !slow || (phase_q == 2'h0);
endmodule // host_sink

// >>> bench/mesh_event_packet_framer_tb_top.sv
`timescale 1ns/1ps
module mesh_event_packet_framer_tb_top;
  import framer_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [3:0] REG_ADDR = 4'h0;
  logic [31:0] REG_WDATA = 32'h0;
  logic [31:0] REG_RDATA;
  logic REG_WR = 1'b0, REG_RD = 1'b0, REQ_VALID = 1'b0, REQ_READY;
  req_type REQ = '0;
  logic FORCE_RESET_CMD = 1'b0, CONFIG_SET_DONE = 1'b0;
  logic SRC_VALID = 1'b0, SRC_LAST = 1'b0, SRC_READY;
  logic [7:0] SRC_DATA = 8'h00, CAND_STRENGTH = 8'h00;
  logic TX_VALID, TX_READY, CAND_VALID = 1'b0;
  logic LINK_ACCEPT_VALID, LINK_ACCEPT, WEAK_ORIGIN_LINK;
  beat_type TX_BEAT;
  logic slow = 1'b0, rd_pend = 1'b0;
  int num_errors = 0, tests_run = 0, seed = 32'hcb5e;
  logic [9:0] exp_q[$];
  logic [8:0] src_q[$];
  logic [31:0] rd_q[$];
  logic acc_q[$];
  logic [31:0] sys_id = 32'h0, node_id = 32'h0;
  logic [7:0] org_str = 8'hFF, org_dep = 8'h00;
  logic [15:0] msg = 16'h0;
  header_type fwd, fwd_exp;
  always #4 CORE_CLK = ~CORE_CLK;
  event_packet_framer #(.FINE_CYCLES(4), .COARSE_CYCLES(10)) i_dut (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .REQ_READY(REQ_READY), .FORCE_RESET_CMD(FORCE_RESET_CMD),
    .CONFIG_SET_DONE(CONFIG_SET_DONE), .SRC_VALID(SRC_VALID),
    .SRC_DATA(SRC_DATA), .SRC_LAST(SRC_LAST), .SRC_READY(SRC_READY),
    .TX_VALID(TX_VALID), .TX_BEAT(TX_BEAT), .TX_READY(TX_READY),
    .CAND_VALID(CAND_VALID), .CAND_STRENGTH(CAND_STRENGTH),
    .LINK_ACCEPT_VALID(LINK_ACCEPT_VALID), .LINK_ACCEPT(LINK_ACCEPT),
    .WEAK_ORIGIN_LINK(WEAK_ORIGIN_LINK));
  host_sink i_host (.clk(CORE_CLK), .rst_b(RST_B), .slow(slow),
    .tx_ready(TX_READY));
  ////////////////////////////////////////////////////////////////////////////
  task automatic bad(input string s);
    num_errors++;
    $display("wrong value at %0t: %s", $time, s);
  endtask
  task automatic cmp_byte(input beat_type got, input logic [9:0] e);
    tests_run++;
    if (got.last !== e[8] || (!e[9] && got.data !== e[7:0])) begin
      bad($sformatf("byte %h expected %h", got, e[8:0]));
    end
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] e);
    tests_run++;
    if (got !== e) bad($sformatf("register %h expected %h", got, e));
  endtask
  task automatic cmp_bit(input logic got, input logic e);
    tests_run++;
    if (got !== e) bad($sformatf("link verdict %b expected %b", got, e));
  endtask
  // result watcher and payload feeder
  always @(posedge CORE_CLK) begin
    rd_pend <= REG_RD;
    if (rd_pend) cmp_word(REG_RDATA, rd_q.pop_front());
    if (LINK_ACCEPT_VALID) cmp_bit(LINK_ACCEPT, acc_q.pop_front());
    if (TX_VALID && TX_READY) cmp_byte(TX_BEAT, exp_q.pop_front());
    if (SRC_VALID && SRC_READY) void'(src_q.pop_front());
    SRC_VALID <= src_q.size() > 0;
    {SRC_LAST, SRC_DATA} <= (src_q.size() > 0) ? src_q[0] : 9'h000;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    REG_WR <= 1'b1;
    REG_RD <= 1'b0;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    REG_RD <= 1'b1;
    REG_WR <= 1'b0;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
  endtask
  // strobes stay up between back-to-back accesses, dropped here
  task automatic reg_idle();
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  function automatic header_type mk(input logic [7:0] ty, dt);
    return '{sys_id, node_id, org_str, org_dep, 8'h00, msg, 16'h0, ty, dt};
  endfunction
  task automatic hdr(input header_type h, input logic dc);
    for (int i = 0; i < 16; i++) begin
      exp_q.push_back({dc && (i == 13 || i == 14), 1'b0, h[135 - 8*i -: 8]});
    end
    exp_q.push_back(10'h000);
    exp_q.push_back(10'h000);
    exp_q.push_back({2'b00, h.detail});
  endtask
  task automatic wait_done(input string name);
    int t = 0;
    while (exp_q.size() != 0 && t < 3000) begin
      @(posedge CORE_CLK);
      t++;
    end
    if (t == 3000) bad("packet stalled");
    @(posedge CORE_CLK);
    $display("test %s ended at %0t", name, $time);
  endtask
  task automatic pkt(input kind_type k, input logic st, se, input int n,
                     input header_type f, e, input logic dc);
    int np;
    logic [7:0] d;
    hdr(e, dc);
    np = (k == KIND_CAL || n > 120) ? 120 : n;
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      src_q.push_back({i == n - 1, d});
      if (i < np) exp_q.push_back({2'b00, d});
    end
    for (int i = n; i < np; i++) exp_q.push_back(10'h000);
    exp_q[exp_q.size() - 1][8] = 1'b1;
    REQ <= '{k, st, se, f};
    REQ_VALID <= 1'b1;
    do @(posedge CORE_CLK); while (REQ_READY !== 1'b1);
    REQ_VALID <= 1'b0;
    wait_done("packet");
    src_q.delete();
  endtask
  task automatic own(input kind_type k, input logic st, se, input int n,
                     input logic [7:0] ty, dt);
    pkt(k, st, se, n, '0, mk(ty, dt), 1'b1);
    msg++;
  endtask
  task automatic notice();
    hdr(mk(PTYPE_EVENT, DETAIL_RESET), 1'b1);
    exp_q[exp_q.size() - 1][8] = 1'b1;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    bad("watchdog expired");
    conclude();
  end
  initial begin
    notice();
    repeat (2) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    reg_rd(ADDR_CTRL, 32'h0000_BE00);
    reg_rd(ADDR_LINK, 32'h0000_00FF);
    reg_rd(4'hF, 32'h0);
    reg_idle();
    wait_done("reset notice");
    reg_rd(ADDR_STATUS, 32'h0001_0001);
    reg_idle();
    cmp_bit(WEAK_ORIGIN_LINK, 1'b1);
    msg = 16'h1;
    sys_id = $random(seed);
    node_id = $random(seed);
    org_str = 8'hBE;
    org_dep = 8'h03;
    reg_wr(ADDR_SYSID, sys_id);
    reg_wr(ADDR_NODE, node_id);
    reg_wr(ADDR_LINK, {16'h0, org_dep, org_str});
    reg_wr(ADDR_CTRL, 32'h0000_8001);
    reg_wr(4'hF, 32'hFFFF_FFFF);
    reg_rd(ADDR_SYSID, sys_id);
    reg_rd(ADDR_NODE, node_id);
    reg_rd(ADDR_LINK, {16'h0, org_dep, org_str});
    reg_rd(ADDR_CTRL, 32'h0000_8001);
    reg_idle();
    cmp_bit(WEAK_ORIGIN_LINK, 1'b0);
    for (int i = 0; i < 3; i++) begin
      CAND_STRENGTH <= (i == 0) ? 8'h80 : (i == 1) ? 8'h81 : 8'h00;
      acc_q.push_back(i != 1);
      CAND_VALID <= 1'b1;
      @(posedge CORE_CLK);
      CAND_VALID <= 1'b0;
      @(posedge CORE_CLK);
    end
    own(KIND_PATH, 1'b0, 1'b0, 7, PTYPE_EVENT, DETAIL_PATH);
    slow <= 1'b1;
    own(KIND_PATH, 1'b0, 1'b0, 125, PTYPE_EVENT, DETAIL_PATH);
    own(KIND_CFG, 1'b0, 1'b0, 4, PTYPE_EVENT, DETAIL_CFG);
    own(kind_type'(3'h7), 1'b0, 1'b0, 2, PTYPE_EVENT, DETAIL_CFG);
    own(KIND_CAL, 1'b0, 1'b0, 3, PTYPE_EVENT, DETAIL_CAL);
    slow <= 1'b0;
    own(KIND_SERIAL, 1'b0, 1'b0, 2, PTYPE_SERIAL, 8'h00);
    own(KIND_SERIAL, 1'b1, 1'b0, 2, PTYPE_SERIAL, 8'h01);
    own(KIND_SERIAL, 1'b1, 1'b1, 2, PTYPE_SERIAL, 8'h02);
    own(KIND_SERIAL, 1'b1, 1'b0, 2, PTYPE_SERIAL, 8'h01);
    fwd = '{32'h1234_5678, 32'h9ABC_DEF0, 8'h40, 8'h02, 8'h05, 16'h0777,
            16'hFFFF, PTYPE_SERIAL, 8'h00};
    fwd_exp = fwd;
    fwd_exp.hop_count = 8'h06;
    pkt(KIND_FWD, 1'b0, 1'b0, 3, fwd, fwd_exp, 1'b0);
    for (int i = 0; i < 2; i++) begin
      msg = 16'h0;
      notice();
      FORCE_RESET_CMD <= (i == 0);
      CONFIG_SET_DONE <= (i == 1);
      @(posedge CORE_CLK);
      FORCE_RESET_CMD <= 1'b0;
      CONFIG_SET_DONE <= 1'b0;
      wait_done("reset command");
      msg = 16'h1;
    end
    own(KIND_PATH, 1'b0, 1'b0, 1, PTYPE_EVENT, DETAIL_PATH);
    conclude();
  end
endmodule // mesh_event_packet_framer_tb_top

bind event_packet_framer framer_checker i_chk (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
  .SRC_VALID(SRC_VALID), .SRC_DATA(SRC_DATA), .SRC_READY(SRC_READY),
  .TX_VALID(TX_VALID), .TX_BEAT(TX_BEAT), .TX_READY(TX_READY),
  .CAND_VALID(CAND_VALID), .LINK_ACCEPT_VALID(LINK_ACCEPT_VALID),
  .LINK_ACCEPT(LINK_ACCEPT), .WEAK_ORIGIN_LINK(WEAK_ORIGIN_LINK));
